// ===== common/blad_pkg.sv
// package for the boot loader and address decoder block
// assumes a single 250 MHz clock domain and an avalon-mm register master
package blad_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned BAUD_RATE       = 9600;
  localparam int unsigned BAUD_DIV        = CLK_HZ / BAUD_RATE;
  localparam int unsigned START_WAIT_MS   = 2000;
  localparam int unsigned START_WAIT_CYC  = (CLK_HZ / 1000) * START_WAIT_MS;
  localparam int unsigned XTAL_BITS       = 20;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [3:0] OFF_TOP_ROM_SEL  = 4'h0;
  localparam logic [3:0] OFF_SLEEP_GATE   = 4'h4;
  localparam logic [3:0] OFF_BOOT_STATUS  = 4'h8;
  localparam logic [3:0] OFF_BOOT_ENTRY   = 4'hc;
  // field positions and reset values
  localparam int unsigned INTERNAL_ROM_SELECT_BIT        = 1;
  localparam int unsigned SLEEP_BIT       = 1;
  localparam logic [7:0] TOP_ROM_RESET    = 8'h02;
  localparam logic [7:0] SLEEP_RESET      = 8'h00;
  // ==========================================================
  // memory map
  localparam logic [15:0] CPU_REG_END     = 16'h001f;
  localparam logic [15:0] DEV_REG_END     = 16'h007f;
  localparam logic [15:0] RAM_END         = 16'h17ff;
  localparam logic [15:0] EXT_PROG_START  = 16'h1800;
  localparam logic [15:0] BANK_START      = 16'h8000;
  localparam logic [15:0] BANK_END        = 16'hbfff;
  localparam logic [15:0] TOP_ROM_START   = 16'hfe00;
  localparam logic [15:0] SLEEP_ADDR      = 16'hffff;
  localparam logic [15:0] RAM_RESET_VEC   = 16'h0ffe;
  localparam logic [15:0] VEC_REMAP_BASE  = 16'h0f00;
  // ==========================================================
  // serial protocol bytes
  localparam logic [7:0] CH_ZERO          = 8'h30;
  localparam logic [7:0] CH_HEX_FMT       = 8'h41;
  localparam logic [7:0] CH_BIN_FMT       = 8'h42;
  localparam logic [7:0] CH_S_LOW         = 8'h73;
  localparam logic [7:0] CH_S_UP          = 8'h53;
  localparam logic [7:0] CKSUM_BASE       = 8'hff;
  // reference divider codes sent to the radio chip
  localparam logic [1:0] XTAL_12M8        = 2'h0;
  localparam logic [1:0] XTAL_14M85       = 2'h1;
  localparam logic [1:0] XTAL_15M36       = 2'h2;

  typedef enum logic [2:0] {
    BLAD_REGION_CPU, BLAD_REGION_DEV, BLAD_REGION_RAM, BLAD_REGION_EXT,
    BLAD_REGION_BANK, BLAD_REGION_INTERNAL_ROM_SELECT
  } blad_region_e;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  data;
  } blad_ram_wr_s;

  typedef struct packed {
    logic        valid;
    logic        rd;
    logic        wr;
    logic [15:0] addr;
  } blad_cpu_bus_s;
endpackage

// ===== core/blad_top.sv
// boot sequencer, serial download engine and system address decoder
// assumes serial rx and straps synchronous to clk_sys; ram is outside
//
// Summary of operation
// - service select sampled at reset release
// - classify crystal from strap, program divider
// - normal start jumps to 1800
// - service start enables serial rx, tx, interrupt
// - frames are 8 data, no parity, 1 stop
// - receive interrupt stays enabled after handover
// - no start code in 2 s means normal
// - 30h 41h selects hex record download
// - records s0 header, s1 data, s9 end
// - checksum is 255 minus byte sum mod 256
// - s9 type jumps via ram vector 0FFE
// - 30h 42h selects binary download, address bounds
// - binary done jumps to start address
// - interrupt vectors redirected into ram in service
// - decoder maps registers, ram, external, rom
// - active low read and write strobes
// - rom select bit routes top page, resets 1
// - sleep gate masks chip select at ffff
//
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
module blad_top
  import blad_pkg::*;
#(
  parameter int unsigned START_WAIT = START_WAIT_CYC,
  parameter int unsigned BIT_DIV    = BAUD_DIV
) (
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  input  wire logic                 service_select_input,
  input  wire logic                 radio_serial_data_line,
  input  wire logic                 serial_rxd,
  output logic                      serial_txd,
  output logic                      serial_rx_enable,
  output logic                      serial_tx_enable,
  output logic                      serial_rx_irq_enable,
  output logic [1:0]                reference_oscillator_divider,
  output logic                      divider_valid,
  output logic                      boot_done,
  output logic [15:0]               boot_entry,
  output blad_ram_wr_s              ram_wr,
  input  blad_cpu_bus_s             cpu_bus,
  output blad_region_e              region,
  output logic                      vector_remap,
  output logic [15:0]               mapped_addr,
  output logic                      program_memory_chip_select_n,
  output logic                      output_enable_n,
  output logic                      write_enable_n,
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest
);
  // ==========================================================
  // boot sequencer
  typedef enum logic [3:0] {
    ST_STRAP, ST_XTAL, ST_MODE, ST_WAIT0, ST_WAITF, ST_HX_S, ST_HX_T,
    ST_HX_BYTE, ST_BN_HDR, ST_BN_DATA, ST_DONE
  } blad_state_e;

  blad_state_e  state;
  logic         service;
  logic [4:0]   strap_cnt;
  logic         seen0;
  logic         seen1;
  logic [31:0]  wait_cnt;
  logic [7:0]   rx_byte;
  logic         rx_stb;
  logic         hex_hi;
  logic [3:0]   hex_nib;
  logic [7:0]   rec_cnt;
  logic [7:0]   rec_idx;
  logic [7:0]   cksum;
  logic         rec_data;
  logic [15:0]  load_addr;
  logic [15:0]  end_addr;
  logic [15:0]  start_addr;
  logic [1:0]   hdr_idx;
  logic [7:0]   top_rom_select_port;
  logic [7:0]   sleep_chip_select_gate_port;
  logic [7:0]   hex_val;
  logic [3:0]   hex_val_hi;
  logic         hex_ok;

  always_comb begin
    hex_ok  = 1'b1;
    hex_nib = 4'h0;
    if (rx_byte >= 8'h30 && rx_byte <= 8'h39) begin
      hex_nib = rx_byte[3:0];
    end else if ((rx_byte | 8'h20) >= 8'h61 && (rx_byte | 8'h20) <= 8'h66) begin
      hex_nib = rx_byte[3:0] + 4'h9;
    end else begin
      hex_ok = 1'b0;
    end
    hex_val = {hex_val_hi, hex_nib};
  end

  // ==========================================================
  // serial receiver: 8 data, no parity, 1 stop, lsb first
  logic [15:0]  rx_div;
  logic [3:0]   rx_bit;
  logic [8:0]   rx_sh;
  logic         rx_busy;

  always_ff @(posedge clk_sys) begin
    rx_stb <= 1'b0;
    if (!resetn || !serial_rx_enable) begin
      rx_busy <= 1'b0;
      rx_div  <= 16'h0000;
      rx_bit  <= 4'h0;
      rx_sh   <= 9'h000;
      rx_byte <= 8'h00;
    end else if (!rx_busy) begin
      if (!serial_rxd) begin
        rx_busy <= 1'b1;
        rx_div  <= 16'(BIT_DIV / 2);
        rx_bit  <= 4'h0;
      end
    end else if (rx_div != 16'h0000) begin
      rx_div <= rx_div - 16'h0001;
    end else begin
      rx_div <= 16'(BIT_DIV - 1);
      rx_sh  <= {serial_rxd, rx_sh[8:1]};
      rx_bit <= rx_bit + 4'h1;
      if (rx_bit == 4'h0 && serial_rxd) begin
        rx_busy <= 1'b0;
      end else if (rx_bit == 4'h9) begin
        rx_busy <= 1'b0;
        if (serial_rxd) begin
          rx_byte <= rx_sh[8:1];
          rx_stb  <= 1'b1;
        end
      end
    end
  end
  // transmitter idles marking; boot code never answers the host
  assign serial_txd = 1'b1;

  // ==========================================================
  // strap sampling and mode latch
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state     <= ST_STRAP;
      service   <= 1'b0;
      strap_cnt <= 5'h00;
      seen0     <= 1'b0;
      seen1     <= 1'b0;
      reference_oscillator_divider <= XTAL_15M36;
      divider_valid <= 1'b0;
      serial_rx_enable     <= 1'b0;
      serial_tx_enable     <= 1'b0;
      serial_rx_irq_enable <= 1'b0;
      vector_remap <= 1'b0;
      boot_done    <= 1'b0;
      boot_entry   <= 16'h0000;
      wait_cnt     <= 32'h0000_0000;
      hex_hi       <= 1'b0;
      hex_val_hi   <= 4'h0;
      rec_cnt      <= 8'h00;
      rec_idx      <= 8'h00;
      cksum        <= 8'h00;
      rec_data     <= 1'b0;
      load_addr    <= 16'h0000;
      end_addr     <= 16'h0000;
      start_addr   <= 16'h0000;
      hdr_idx      <= 2'h0;
      ram_wr       <= '0;
    end else begin
      ram_wr.we <= 1'b0;
      if (state != ST_STRAP && state != ST_DONE && wait_cnt != 32'hffff_ffff) begin
        wait_cnt <= wait_cnt + 32'h0000_0001;
      end
      case (state)
        ST_STRAP: begin
          service <= service_select_input;
          state   <= ST_XTAL;
        end
        ST_XTAL: begin
          if (radio_serial_data_line) seen1 <= 1'b1;
          else seen0 <= 1'b1;
          strap_cnt <= strap_cnt + 5'h01;
          if (strap_cnt == 5'(XTAL_BITS - 1)) state <= ST_MODE;
        end
        ST_MODE: begin
          divider_valid <= 1'b1;
          if (!seen1) reference_oscillator_divider <= XTAL_12M8;
          else if (!seen0) reference_oscillator_divider <= XTAL_15M36;
          else reference_oscillator_divider <= XTAL_14M85;
          if (service) begin
            serial_rx_enable     <= 1'b1;
            serial_tx_enable     <= 1'b1;
            serial_rx_irq_enable <= 1'b1;
            vector_remap         <= 1'b1;
            state <= ST_WAIT0;
          end else begin
            boot_entry <= EXT_PROG_START;
            boot_done  <= 1'b1;
            state      <= ST_DONE;
          end
        end
        ST_WAIT0, ST_WAITF: begin
          if (wait_cnt >= START_WAIT) begin
            vector_remap <= 1'b0;
            boot_entry   <= EXT_PROG_START;
            boot_done    <= 1'b1;
            state        <= ST_DONE;
          end else if (rx_stb) begin
            if (state == ST_WAITF && rx_byte == CH_HEX_FMT) state <= ST_HX_S;
            else if (state == ST_WAITF && rx_byte == CH_BIN_FMT) begin
              state   <= ST_BN_HDR;
              hdr_idx <= 2'h0;
            end else if (rx_byte == CH_ZERO) state <= ST_WAITF;
            else state <= ST_WAIT0;
          end
        end
        ST_HX_S: begin
          if (rx_stb && (rx_byte == CH_S_LOW || rx_byte == CH_S_UP)) state <= ST_HX_T;
        end
        ST_HX_T: begin
          if (rx_stb) begin
            if (rx_byte == 8'h39) begin
              boot_entry <= RAM_RESET_VEC;
              boot_done  <= 1'b1;
              state      <= ST_DONE;
            end else begin
              rec_data <= (rx_byte == 8'h31);
              rec_idx  <= 8'h00;
              cksum    <= 8'h00;
              hex_hi   <= 1'b1;
              state    <= ST_HX_BYTE;
            end
          end
        end
        ST_HX_BYTE: begin
          if (rx_stb && hex_ok) begin
            if (hex_hi) begin
              hex_val_hi <= hex_nib;
              hex_hi     <= 1'b0;
            end else begin
              hex_hi  <= 1'b1;
              rec_idx <= rec_idx + 8'h01;
              if (rec_idx == 8'h00) begin
                rec_cnt <= hex_val;
                cksum   <= hex_val;
              end else if (rec_idx == rec_cnt) begin
                // bad checksum is not acted on; writes already made stand
                if (8'(CKSUM_BASE - cksum) != hex_val) begin end
                state <= ST_HX_S;
              end else begin
                cksum <= cksum + hex_val;
                if (rec_idx == 8'h01) load_addr[15:8] <= hex_val;
                else if (rec_idx == 8'h02) load_addr[7:0] <= hex_val;
                else if (rec_data) begin
                  ram_wr.we   <= 1'b1;
                  ram_wr.addr <= load_addr;
                  ram_wr.data <= hex_val;
                  load_addr   <= load_addr + 16'h0001;
                end
              end
            end
          end
        end
        ST_BN_HDR: begin
          if (rx_stb) begin
            hdr_idx <= hdr_idx + 2'h1;
            case (hdr_idx)
              2'h0: start_addr[15:8] <= rx_byte;
              2'h1: start_addr[7:0]  <= rx_byte;
              2'h2: end_addr[15:8]   <= rx_byte;
              default: begin
                end_addr[7:0] <= rx_byte;
                load_addr     <= start_addr;
                state         <= ST_BN_DATA;
              end
            endcase
          end
        end
        ST_BN_DATA: begin
          if (load_addr == end_addr) begin
            boot_entry <= start_addr;
            boot_done  <= 1'b1;
            state      <= ST_DONE;
          end else if (rx_stb) begin
            ram_wr.we   <= 1'b1;
            ram_wr.addr <= load_addr;
            ram_wr.data <= rx_byte;
            load_addr   <= load_addr + 16'h0001;
          end
        end
        ST_DONE: begin
          state <= ST_DONE;
        end
        default: state <= ST_STRAP;
      endcase
    end
  end

  // ==========================================================
  // address decoder
  logic internal_rom_select_sel;
  logic sleep_gate;
  logic ext_hit;
  assign internal_rom_select_sel   = top_rom_select_port[INTERNAL_ROM_SELECT_BIT];
  assign sleep_gate = sleep_chip_select_gate_port[SLEEP_BIT];

  always_comb begin
    if (cpu_bus.addr <= CPU_REG_END) region = BLAD_REGION_CPU;
    else if (cpu_bus.addr <= DEV_REG_END) region = BLAD_REGION_DEV;
    else if (cpu_bus.addr <= RAM_END) region = BLAD_REGION_RAM;
    else if (cpu_bus.addr >= BANK_START && cpu_bus.addr <= BANK_END) region = BLAD_REGION_BANK;
    else if (cpu_bus.addr >= TOP_ROM_START && internal_rom_select_sel) region = BLAD_REGION_INTERNAL_ROM_SELECT;
    else region = BLAD_REGION_EXT;
    // vectors fetched in the top page land in ram while remapped
    mapped_addr = cpu_bus.addr;
    if (vector_remap && cpu_bus.addr[15:4] == 12'hfff) begin
      mapped_addr = {VEC_REMAP_BASE[15:8], cpu_bus.addr[7:0]};
    end else if (vector_remap && cpu_bus.addr[15:4] == 12'hffe) begin
      mapped_addr = {VEC_REMAP_BASE[15:8], cpu_bus.addr[7:0]};
    end
  end

  assign ext_hit = cpu_bus.valid && (region == BLAD_REGION_EXT || region == BLAD_REGION_BANK)
                   && !(sleep_gate && cpu_bus.addr == SLEEP_ADDR);

  // strobes registered so they are glitch free toward memories
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      program_memory_chip_select_n <= 1'b1;
      output_enable_n <= 1'b1;
      write_enable_n  <= 1'b1;
    end else begin
      program_memory_chip_select_n <= !ext_hit;
      output_enable_n <= !(ext_hit && cpu_bus.rd);
      write_enable_n  <= !(ext_hit && cpu_bus.wr && !cpu_bus.rd);
    end
  end

  // ==========================================================
  // avalon-mm slave, one wait state on reads
  logic rd_pend;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      top_rom_select_port <= TOP_ROM_RESET;
      sleep_chip_select_gate_port <= SLEEP_RESET;
      rd_pend      <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_pend <= avs_read && !rd_pend;
      if (avs_write) begin
        case (avs_address)
          OFF_TOP_ROM_SEL: top_rom_select_port <= avs_writedata[7:0];
          OFF_SLEEP_GATE:  sleep_chip_select_gate_port <= avs_writedata[7:0];
          default: ;
        endcase
      end
      if (avs_read && !rd_pend) begin
        case (avs_address)
          OFF_TOP_ROM_SEL: avs_readdata <= {24'h00_0000, top_rom_select_port};
          OFF_SLEEP_GATE:  avs_readdata <= {24'h00_0000, sleep_chip_select_gate_port};
          OFF_BOOT_STATUS: avs_readdata <= {24'h00_0000, 4'h0, divider_valid,
                                             reference_oscillator_divider, boot_done};
          OFF_BOOT_ENTRY:  avs_readdata <= {16'h0000, boot_entry};
          default:         avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign avs_waitrequest = avs_read && !rd_pend;
endmodule

// ===== dv/blad_assertions.sv
// port checker for blad_top, decoder and boot handover
// bound to blad_top; one clock domain, sync active low reset
`timescale 1ns/1ps
module blad_assertions
  import blad_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        resetn,
  input blad_cpu_bus_s    cpu_bus,
  input blad_region_e     region,
  input blad_ram_wr_s     ram_wr,
  input wire logic        vector_remap,
  input wire logic [15:0] mapped_addr,
  input wire logic        program_memory_chip_select_n,
  input wire logic        output_enable_n,
  input wire logic        write_enable_n,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        serial_rx_enable,
  input wire logic        serial_tx_enable,
  input wire logic        serial_rx_irq_enable,
  input wire logic        boot_done,
  input wire logic [15:0] boot_entry
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // helpers
  wire ext_lo = (cpu_bus.addr >= EXT_PROG_START) && (cpu_bus.addr < BANK_START);
  wire idle_strb = program_memory_chip_select_n & output_enable_n & write_enable_n;
  function automatic blad_region_e exp_region(input logic [15:0] a);
    if (a <= CPU_REG_END) return BLAD_REGION_CPU;
    if (a <= DEV_REG_END) return BLAD_REGION_DEV;
    if (a <= RAM_END) return BLAD_REGION_RAM;
    if (a >= BANK_START && a <= BANK_END) return BLAD_REGION_BANK;
    return BLAD_REGION_EXT;
  endfunction
  sequence s_read_wait;
    avs_waitrequest;
  endsequence
  sequence s_read_answer;
    !avs_waitrequest;
  endsequence
  // ==========================================================
  // assertions
  a_strobe_rst_idle: assert property (disable iff (1'b0) !resetn |=> idle_strb)
    else $error("strobe active after reset");
  a_internal_no_cs: assert property (cpu_bus.valid && cpu_bus.addr <= RAM_END |=> idle_strb)
    else $error("strobe for internal address");
  a_ext_rd_strobe: assert property (cpu_bus.valid && cpu_bus.rd && ext_lo
    |=> !program_memory_chip_select_n && !output_enable_n && write_enable_n)
    else $error("bad external read strobes");
  a_ext_wr_strobe: assert property (cpu_bus.valid && cpu_bus.wr && ext_lo
    |=> !program_memory_chip_select_n && output_enable_n && !write_enable_n)
    else $error("bad external write strobes");
  a_idle_no_strobe: assert property (!cpu_bus.valid |=> idle_strb)
    else $error("strobe without access");
  a_region_map: assert property (cpu_bus.addr < TOP_ROM_START |-> region == exp_region(cpu_bus.addr))
    else $error("wrong region");
  a_vector_remap: assert property (vector_remap && cpu_bus.addr >= 16'hffe0
    |-> mapped_addr == {4'h0, cpu_bus.addr[11:0]})
    else $error("vector not remapped");
  a_read_wait: assert property ($rose(avs_read) |-> s_read_wait ##1 s_read_answer)
    else $error("read answer timing");
  a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  a_serial_stays_on: assert property (serial_rx_enable
    |=> serial_rx_enable && serial_tx_enable && serial_rx_irq_enable)
    else $error("serial enable dropped");
  a_entry_holds: assert property (boot_done |=> boot_done && $stable(boot_entry))
    else $error("boot entry changed");
  a_store_pulse: assert property (ram_wr.we |=> !ram_wr.we)
    else $error("ram store not a pulse");
endmodule

bind blad_top blad_assertions u_blad_assertions (
  .clk_sys(clk_sys), .resetn(resetn), .cpu_bus(cpu_bus), .region(region), .ram_wr(ram_wr),
  .vector_remap(vector_remap), .mapped_addr(mapped_addr),
  .program_memory_chip_select_n(program_memory_chip_select_n),
  .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .serial_rx_enable(serial_rx_enable), .serial_tx_enable(serial_tx_enable),
  .serial_rx_irq_enable(serial_rx_irq_enable), .boot_done(boot_done), .boot_entry(boot_entry)
);

// ===== dv/blad_host_model.sv
// serial download host: frames, start codes and hex records
// tasks are called by the bench just after a rising edge
`timescale 1ns/1ps
module blad_host_model #(
  parameter int unsigned BIT_DIV = 16
) (
  input  wire logic clk_sys,
  output logic      serial_rxd
);
  logic [7:0] sum;
  initial serial_rxd = 1'b1;
  // start bit, 8 data lsb first, no parity, stop bit, then idle high
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frm;
    frm = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      serial_rxd <= frm[i];
      repeat (BIT_DIV) @(posedge clk_sys);
    end
  endtask
  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
  endfunction
  task automatic send_hex(input logic [7:0] b);
    sum = sum + b;
    send_byte(hex_ch(b[7:4]));
    send_byte(hex_ch(b[3:0]));
  endtask
  // record type char t, then count, body bytes and ones-complement sum
  task automatic send_rec(input logic [7:0] t, input logic [7:0] q[$]);
    sum = 8'h00;
    send_byte(8'h53);
    send_byte(t);
    send_hex(8'(q.size() + 1));
    foreach (q[i]) send_hex(q[i]);
    send_hex(~sum);
  endtask
endmodule

// ===== dv/blad_top_tb_top.sv
// directed bench for blad_top: boot modes, download and decoder
// host model drives serial_rxd; timing counts shortened by parameters
`timescale 1ns/1ps
module blad_top_tb_top
  import blad_pkg::*;
;
  localparam int unsigned SW = 20000;
  localparam int unsigned BD = 16;
  logic          clk_sys = 1'b0, resetn = 1'b0, service_select_input = 1'b0;
  logic          radio_serial_data_line = 1'b0, serial_rxd, serial_txd, divider_valid;
  logic          serial_rx_enable, serial_tx_enable, serial_rx_irq_enable, boot_done;
  logic          vector_remap, program_memory_chip_select_n, output_enable_n, write_enable_n;
  logic [1:0]    strap_mode = 2'h0, reference_oscillator_divider;
  logic [15:0]   boot_entry, mapped_addr;
  blad_ram_wr_s  ram_wr;
  blad_cpu_bus_s cpu_bus = '0;
  blad_region_e  region;
  logic [3:0]    avs_address = 4'h0;
  logic          avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0]   avs_writedata = 32'h0000_0000, avs_readdata;
  logic [23:0]   ram_q[$];
  int unsigned   n_fail = 0, num_checks = 0, cyc = 0;

  blad_top #(.START_WAIT(SW), .BIT_DIV(BD)) u_blad_top (.*);
  blad_host_model #(.BIT_DIV(BD)) u_blad_host_model (.clk_sys(clk_sys), .serial_rxd(serial_rxd));

  always #2 clk_sys = ~clk_sys;
  // strap: 0 low, 1 high, 2 toggling (neither all zeros nor all ones)
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    radio_serial_data_line <= (strap_mode == 2'h2) ? ~radio_serial_data_line : strap_mode[0];
    if (ram_wr.we === 1'b1)
      ram_q.push_back({ram_wr.addr, ram_wr.data});
    if (cyc == 60000) begin
      n_fail++;
      finish_test();
    end
  end
  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic do_reset(input logic svc, input logic [1:0] sm);
    @(posedge clk_sys);
    resetn <= 1'b0;
    service_select_input <= svc;
    strap_mode <= sm;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (40) @(posedge clk_sys);
    ram_q.delete();
  endtask
  task automatic wait_done(input int unsigned lim);
    for (int i = 0; i < lim && boot_done !== 1'b1; i++) @(posedge clk_sys);
    @(negedge clk_sys);
    chk("boot_done", 1, boot_done);
  endtask
  // waitrequest and readdata are taken as they stand into the edge
  task automatic avs_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~wr;
    avs_write <= wr;
    do @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    avs_xfer(1'b0, a, 32'h0000_0000, q);
    chk(nm, e, q);
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    avs_xfer(1'b1, a, d, q);
  endtask
  // expected {chip select, output enable, write enable} under mask m
  task automatic cpu_chk(input logic [15:0] a, input logic rd, input logic [2:0] e,
                         input logic [2:0] m);
    @(posedge clk_sys);
    cpu_bus <= '{valid: 1'b1, rd: rd, wr: ~rd, addr: a};
    @(posedge clk_sys);
    cpu_bus.valid <= 1'b0;
    @(negedge clk_sys);
    chk("strobes", e & m, {program_memory_chip_select_n, output_enable_n, write_enable_n} & m);
  endtask
  task automatic ram_chk(input logic [15:0] base, input logic [23:0] d);
    chk("ram_count", 3, ram_q.size());
    for (int i = 0; i < 3; i++)
      chk("ram_wr", {base + 16'(i), d[23 - 8 * i -: 8]}, ram_q[i]);
  endtask
  // ==========================================================
  // scenarios
  task automatic test_normal();
    do_reset(1'b0, 2'h0);
    wait_done(200);
    chk("divider", XTAL_12M8, reference_oscillator_divider);
    chk("entry", EXT_PROG_START, boot_entry);
    chk("rx_enable", 0, serial_rx_enable);
  endtask
  task automatic test_decoder();
    rd_chk("rom_sel", OFF_TOP_ROM_SEL, 32'h0000_0002);
    rd_chk("sleep", OFF_SLEEP_GATE, 32'h0000_0000);
    rd_chk("unmapped", 4'h1, 32'h0000_0000);
    wr_reg(OFF_BOOT_STATUS, 32'h0000_0000);
    rd_chk("status", OFF_BOOT_STATUS, 32'h0000_0009);
    cpu_chk(16'hfe00, 1'b1, 3'h7, 3'h7);
    cpu_chk(16'h0100, 1'b1, 3'h7, 3'h7);
    cpu_chk(16'h1800, 1'b1, 3'h1, 3'h7);
    cpu_chk(16'hc000, 1'b0, 3'h2, 3'h7);
    cpu_chk(16'h8000, 1'b1, 3'h1, 3'h7);
    wr_reg(OFF_TOP_ROM_SEL, 32'h0000_0000);
    rd_chk("rom_sel", OFF_TOP_ROM_SEL, 32'h0000_0000);
    cpu_chk(16'hfe00, 1'b1, 3'h1, 3'h7);
    cpu_chk(16'hffff, 1'b1, 3'h0, 3'h4);
    wr_reg(OFF_SLEEP_GATE, 32'h0000_0002);
    cpu_chk(16'hffff, 1'b1, 3'h4, 3'h4);
  endtask
  task automatic test_timeout();
    do_reset(1'b1, 2'h1);
    u_blad_host_model.send_byte(CH_ZERO);
    u_blad_host_model.send_byte(8'h55);
    u_blad_host_model.send_byte(CH_HEX_FMT);
    chk("early_done", 0, boot_done);
    chk("rx_irq", 1, serial_rx_irq_enable);
    chk("txd", 1, serial_txd);
    wait_done(SW + 500);
    chk("entry", EXT_PROG_START, boot_entry);
    chk("divider", XTAL_15M36, reference_oscillator_divider);
  endtask
  task automatic test_hex();
    logic [15:0] vec[8] = '{16'hfffe, 16'hffee, 16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4,
                            16'hfff2, 16'hfff0};
    do_reset(1'b1, 2'h2);
    // load addresses stay clear of the loader's working ram
    u_blad_host_model.send_byte(CH_ZERO);
    u_blad_host_model.send_byte(CH_HEX_FMT);
    u_blad_host_model.send_rec(8'h30, {8'h00, 8'h00, 8'h4e, 8'h4d});
    u_blad_host_model.send_rec(8'h31, {8'h02, 8'h00, 8'ha1, 8'hb2, 8'hc3});
    u_blad_host_model.send_rec(8'h39, {8'h02, 8'h00});
    wait_done(10);
    ram_chk(16'h0200, 24'ha1_b2c3);
    chk("entry", RAM_RESET_VEC, boot_entry);
    chk("divider", XTAL_14M85, reference_oscillator_divider);
    chk("irq_after", 1, serial_rx_irq_enable);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      cpu_bus.addr <= vec[i];
      @(negedge clk_sys);
      chk("mapped_addr", {4'h0, vec[i][11:0]}, mapped_addr);
    end
  endtask
  task automatic test_bin();
    logic [7:0] bytes[9] = '{CH_ZERO, CH_BIN_FMT, 8'h03, 8'h00, 8'h03, 8'h03,
                             8'hd1, 8'he2, 8'hf3};
    do_reset(1'b1, 2'h0);
    foreach (bytes[i]) u_blad_host_model.send_byte(bytes[i]);
    wait_done(100);
    ram_chk(16'h0300, 24'hd1_e2f3);
    chk("entry", 16'h0300, boot_entry);
    rd_chk("entry_reg", OFF_BOOT_ENTRY, 32'h0000_0300);
  endtask

  initial begin
    test_normal();
    test_decoder();
    test_timeout();
    test_hex();
    test_bin();
    finish_test();
  end
endmodule
